// ===== hw/io_line_function_mux.sv
// pin multiplexer for three i/o controllers of up to 32 lines each
module io_line_function_mux (
  input  wire logic i_clk_sys,                                               // system clock
  input  wire logic i_rst_n,                                                 // sync reset, active low
  input  wire logic [io_mux_pkg::NUM_CTRL-1:0] i_cfg_we,                     // load selection for a controller
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_psel, // new peripheral select
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_bsel, // new a/b choice
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_pullup, // new pull-up enables
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_gpio_o,  // gpio output values
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_gpio_oe, // gpio output enables
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_a_o,     // function a outputs
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_a_oe,    // function a enables
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_b_o,     // function b outputs
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_b_oe,    // function b enables
  input  wire logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] i_pin_i,   // pin input levels
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_pin_o,        // pin output values
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_pin_oe,       // pin output enables
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_pullup,       // pull-up enables
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_peripheral_select_status, // 1: peripheral
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_func_select_b, // current a/b choice
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_a_i,          // pin level to function a
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_b_i,          // pin level to function b
  output logic [io_mux_pkg::NUM_CTRL*io_mux_pkg::NUM_LINES-1:0] o_gpio_i        // pin level to gpio
);
  import io_mux_pkg::*;

  localparam int W = NUM_CTRL * NUM_LINES;
  // controller a first, then b, then c; line n of controller k is bit k*32+n
  localparam logic [W-1:0] RST_PSEL = {RST_PSEL_C, RST_PSEL_B, RST_PSEL_A}; // RULE8
  localparam logic [W-1:0] RST_BSEL = {RST_BSEL_C, RST_BSEL_B, RST_BSEL_A};
  localparam logic [W-1:0] RST_PU = {RST_PULLUP, RST_PULLUP, RST_PULLUP};

  // who drives a line and whose input path hears it
  typedef enum logic [1:0] {
    OWNER_GPIO,
    OWNER_FUNC_A,
    OWNER_FUNC_B
  } line_owner_t;

  // a line is addressed by its controller and its bit position there
  function automatic int flat_index(input int ctrl, input int pos);
    return ctrl * NUM_LINES + pos; // RULE1
  endfunction

  // one controller's lines out of a flat vector
  function automatic logic [NUM_LINES-1:0] ctrl_slice(input logic [W-1:0] vec, input int ctrl);
    return vec[flat_index(ctrl, 0) +: NUM_LINES];
  endfunction

  // owner decode, shared by the input steering of every line
  function automatic line_owner_t owner_of(input logic psel, input logic bsel);
    line_owner_t own;
    if (!psel) begin
      own = OWNER_GPIO;
    end else if (bsel) begin
      own = OWNER_FUNC_B;
    end else begin
      own = OWNER_FUNC_A;
    end
    return own;
  endfunction

  // gpio may drive only once reset is released, so gpio-reset lines come up as inputs
  function automatic logic gpio_drive(input logic oe, input logic rst_n);
    return oe & rst_n;
  endfunction

  genvar c;
  genvar n;
  generate
    for (c = 0; c < NUM_CTRL; c++) begin : g_ctrl
      localparam int BASE = flat_index(c, 0);
      logic load;
      logic [NUM_LINES-1:0] psel_ff;
      logic [NUM_LINES-1:0] bsel_ff;
      logic [NUM_LINES-1:0] pullup_ff;

      // one strobe reloads all lines of its controller; the reset branch wins over it
      assign load = i_cfg_we[c];

      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          psel_ff <= ctrl_slice(RST_PSEL, c); // RULE4 RULE5
        end else if (load) begin
          psel_ff <= ctrl_slice(i_psel, c); // RULE2
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          bsel_ff <= ctrl_slice(RST_BSEL, c); // RULE5
        end else if (load) begin
          bsel_ff <= ctrl_slice(i_bsel, c); // RULE2
        end
      end

      // pull-ups on for every line at reset, whatever its reset owner
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          pullup_ff <= ctrl_slice(RST_PU, c); // RULE3 RULE6
        end else if (load) begin
          pullup_ff <= ctrl_slice(i_pullup, c);
        end
      end

      assign o_peripheral_select_status[BASE +: NUM_LINES] = psel_ff; // RULE4
      assign o_func_select_b[BASE +: NUM_LINES] = bsel_ff;
      assign o_pullup[BASE +: NUM_LINES] = pullup_ff;

      for (n = 0; n < NUM_LINES; n++) begin : g_line
        localparam int B = flat_index(c, n);
        line_owner_t own;
        logic gpio_oe;
        logic a_in;
        logic b_in;

        assign own = owner_of(psel_ff[n], bsel_ff[n]);
        assign gpio_oe = gpio_drive(i_gpio_oe[B], i_rst_n); // RULE3

        // a duplicated output-only function simply has its source fanned to several lines
        io_line_cell u_cell (
          .i_psel(psel_ff[n]),
          .i_bsel(bsel_ff[n]),
          .i_gpio_o(i_gpio_o[B]),
          .i_gpio_oe(gpio_oe),
          .i_a_o(i_a_o[B]),
          .i_a_oe(i_a_oe[B]),
          .i_b_o(i_b_o[B]),
          .i_b_oe(i_b_oe[B]),
          .o_pin_o(o_pin_o[B]), // RULE7
          .o_pin_oe(o_pin_oe[B])
        );

        // input paths of functions that do not own the line idle high
        always_comb begin
          a_in = 1'b1;
          b_in = 1'b1;
          case (own)
            OWNER_FUNC_A: begin
              a_in = i_pin_i[B]; // RULE2
            end
            OWNER_FUNC_B: begin
              b_in = i_pin_i[B]; // RULE2
            end
            default: begin
              a_in = 1'b1;
              b_in = 1'b1;
            end
          endcase
        end

        assign o_a_i[B] = a_in;
        assign o_b_i[B] = b_in;
        assign o_gpio_i[B] = i_pin_i[B];
      end
    end
  endgenerate
endmodule

// ===== hw/io_mux_pkg.sv
// constants shared by the i/o line function mux
// How it works
// RULE1: three controllers, each with up to 32 lines indexed by bit position.
// RULE2: each line routes function a or function b instead of general-purpose use.
// RULE3: lines resetting as general-purpose come up as inputs with pull-up on.
// RULE4: general-purpose reset lines read zero in peripheral-select status after reset.
// RULE5: lines resetting to a named function connect to it; status bit reads one.
// RULE6: lines resetting to a peripheral function also have pull-up enabled.
// RULE7: an output-only signal drives every line whose selection points to it.
// RULE8: every line of controller a resets in general-purpose mode.
package io_mux_pkg;
  localparam int NUM_CTRL = 3;
  localparam int NUM_LINES = 32;
  // reset peripheral-select status per controller; controller c lines 4,5,10 are address lines
  localparam logic [31:0] RST_PSEL_A = 32'h0000_0000;
  localparam logic [31:0] RST_PSEL_B = 32'h0000_0000;
  localparam logic [31:0] RST_PSEL_C = 32'h0000_0430;
  // reset function choice for peripheral-mode lines: 0 = function a
  localparam logic [31:0] RST_BSEL_A = 32'h0000_0000;
  localparam logic [31:0] RST_BSEL_B = 32'h0000_0000;
  localparam logic [31:0] RST_BSEL_C = 32'h0000_0000;
  localparam logic [31:0] RST_PULLUP = 32'hFFFF_FFFF;
endpackage

// ===== hw/io_line_cell.sv
// one i/o line: selects gpio, function a or function b onto the pin
module io_line_cell (
  input  wire logic i_psel,    // 1: peripheral owns the line
  input  wire logic i_bsel,    // 1: function b, 0: function a
  input  wire logic i_gpio_o,  // gpio output value
  input  wire logic i_gpio_oe, // gpio output enable
  input  wire logic i_a_o,     // function a output
  input  wire logic i_a_oe,    // function a output enable
  input  wire logic i_b_o,     // function b output
  input  wire logic i_b_oe,    // function b output enable
  output logic o_pin_o,        // pin output value
  output logic o_pin_oe        // pin output enable
);
  always_comb begin
    if (!i_psel) begin
      o_pin_o = i_gpio_o;
      o_pin_oe = i_gpio_oe;
    end else if (i_bsel) begin
      o_pin_o = i_b_o; // RULE2
      o_pin_oe = i_b_oe;
    end else begin
      o_pin_o = i_a_o; // RULE2
      o_pin_oe = i_a_oe;
    end
  end
endmodule

// ===== test/io_mux_peer.sv
// far-side model: peripheral and gpio sources, and pin levels
module io_mux_peer (
  input wire logic i_clk_sys,
  input wire logic [95:0] o_pin_o, o_pin_oe, o_pullup,
  output logic [95:0] i_gpio_o, i_gpio_oe, i_a_o, i_a_oe, i_b_o, i_b_oe, i_pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [95:0] ext, ext_oe, flip = '0;
  function automatic logic [95:0] r();
    return {$urandom, $urandom, $urandom};
  endfunction
  // a floating line without pull-up toggles, so a stale level never looks valid
  assign i_pin_i = o_pin_oe & o_pin_o | ~o_pin_oe & (ext_oe & ext | ~ext_oe & (o_pullup | flip));
  initial forever begin
    {i_gpio_o, i_gpio_oe, i_a_o, i_a_oe} <= {r(), r(), r(), r()};
    {i_b_o, i_b_oe, ext, ext_oe, flip} <= {r(), r(), r(), r() & r(), ~flip};
    @(negedge i_clk_sys);
  end
endmodule

// ===== test/io_line_function_mux_sva.sv
// port assertions for the i/o line function mux
module io_mux_sva (
  input wire logic i_clk_sys, i_rst_n,
  input wire logic [2:0] i_cfg_we,
  input wire logic [95:0] i_psel, i_gpio_o, i_gpio_oe, i_a_o, i_a_oe, i_b_o, i_b_oe,
  input wire logic [95:0] o_pin_o, o_pin_oe, o_pullup, o_peripheral_select_status, o_func_select_b
);
  default clocking @(posedge i_clk_sys); endclocking
  wire [95:0] st = o_peripheral_select_status;
  wire [95:0] fb = o_func_select_b;
  a_reset_status: assert property (!i_rst_n |=> st == 96'h0000_0430_0000_0000_0000_0000)
    else $error("reset select status wrong");
  a_reset_pullup: assert property (!i_rst_n |=> &o_pullup) else $error("pull-up off after reset");
  a_reset_func_a: assert property (!i_rst_n |=> fb == '0) else $error("reset function not a");
  a_reset_input: assert property (!i_rst_n ##1 !i_rst_n |-> (o_pin_oe & ~st) == '0)
    else $error("gpio line driven in reset");
  a_load_ctrl_c: assert property (disable iff (!i_rst_n) i_cfg_we[2] |=> st[95:64] == $past(i_psel[95:64]))
    else $error("select load lost");
  a_hold_choice: assert property (disable iff (!i_rst_n) !i_cfg_we[0] |=> $stable(fb[31:0]))
    else $error("a/b choice moved without load");
  a_pin_value: assert property (disable iff (!i_rst_n)
    o_pin_o == (~st & i_gpio_o | st & ~fb & i_a_o | st & fb & i_b_o)) else $error("pin value mux wrong");
  a_pin_enable: assert property (disable iff (!i_rst_n)
    o_pin_oe == (~st & i_gpio_oe | st & ~fb & i_a_oe | st & fb & i_b_oe)) else $error("pin enable mux wrong");
endmodule
bind io_line_function_mux io_mux_sva u_io_mux_sva (.*);

// ===== test/io_line_function_mux_test.sv
// self-checking bench for the i/o line function mux
module io_line_function_mux_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_rst_n = 0;
  logic [2:0] i_cfg_we = '0;
  logic [95:0] i_psel = '0, i_bsel = '0, i_pullup = '0, i_gpio_o, i_gpio_oe, i_a_o, i_a_oe, i_b_o, i_b_oe, i_pin_i;
  logic [95:0] o_pin_o, o_pin_oe, o_pullup, o_peripheral_select_status, o_func_select_b, o_a_i, o_b_i, o_gpio_i;
  logic [95:0] ms, mf, mp;
  int failures = 0, cmp_count = 0, cyc = 0;
  io_line_function_mux u_io_line_function_mux (.*);
  io_mux_peer u_io_mux_peer (.*);
  initial forever #50 i_clk_sys = ~i_clk_sys;
  function automatic logic [95:0] r();
    return {$urandom, $urandom, $urandom};
  endfunction
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic check();
    chk(o_peripheral_select_status, ms);
    chk(o_pullup, mp);
    chk(o_func_select_b, mf);
    chk(o_pin_o, ~ms & i_gpio_o | ms & ~mf & i_a_o | ms & mf & i_b_o);
    chk(o_pin_oe, ~ms & i_gpio_oe & {96{i_rst_n}} | ms & ~mf & i_a_oe | ms & mf & i_b_oe);
    chk(o_a_i, i_pin_i | ~(ms & ~mf));
    chk(o_b_i, i_pin_i | ~(ms & mf));
    chk(o_gpio_i, i_pin_i);
  endtask
  task automatic results();
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // about 2010 cycles are needed; the ceiling only catches a hang
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    void'($urandom(21));
    {ms, mf, mp} = {96'h0000_0430_0000_0000_0000_0000, 96'h0, ~96'h0};
    repeat (8) @(negedge i_clk_sys);
    i_rst_n = 1;
    // random strobes also land in mid-run resets, where they must be ignored
    repeat (2000) begin
      @(negedge i_clk_sys);
      check();
      i_rst_n = ($urandom % 64) != 0;
      i_cfg_we = 3'($urandom);
      {i_psel, i_bsel, i_pullup} = {r(), r(), r()};
      if (!i_rst_n) {ms, mf, mp} = {96'h0000_0430_0000_0000_0000_0000, 96'h0, ~96'h0};
      else for (int k = 0; k < 3; k++) if (i_cfg_we[k]) begin
        {ms[k*32+:32], mf[k*32+:32], mp[k*32+:32]} = {i_psel[k*32+:32], i_bsel[k*32+:32], i_pullup[k*32+:32]};
      end
    end
    results();
  end
endmodule
